// ==== hw/pmt_pkg.sv ====
`default_nettype none

package pmt_pkg;

    // Prescale select codes; both upper codes divide by sixteen.
    typedef enum logic [1:0] {
        PMT_DIV1   = 2'h0,
        PMT_DIV4   = 2'h1,
        PMT_DIV16  = 2'h2,
        PMT_DIV16B = 2'h3
    } pmt_presc_t;

endpackage

`default_nettype wire

// ==== hw/pmt_postscaler.sv ====
`default_nettype none

module pmt_postscaler (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clr_i,
    input  wire logic       en_i,
    input  wire logic [3:0] sel_i,
    output logic            tick_o,
    output logic [3:0]      cnt_o
);

    logic [3:0] cnt_q;

    // One tick for every sel_i plus one matches.
    assign tick_o = en_i && !clr_i && (cnt_q == sel_i);
    assign cnt_o  = cnt_q;

    // Counts matches and wraps when the selected ratio is reached.
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_q <= 4'h0;
        end else if (en_i) begin
            cnt_q <= tick_o ? 4'h0 : cnt_q + 4'h1;
        end
    end

endmodule

`default_nettype wire

// ==== hw/pmt_prescaler.sv ====
`include "pmt_regs.svh"
`default_nettype none

module pmt_prescaler (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               clr_i,
    input  wire logic               en_i,
    input  wire pmt_pkg::pmt_presc_t sel_i,
    output logic                    tick_o,
    output logic [3:0]              cnt_o
);

    logic [3:0] cnt_q;

    // Maps a prescale code to the last count before a tick.
    function automatic logic [3:0] presc_limit(input pmt_pkg::pmt_presc_t sel);    // R2
        case (sel)
            pmt_pkg::PMT_DIV1: presc_limit = `PMT_LIM_DIV1;
            pmt_pkg::PMT_DIV4: presc_limit = `PMT_LIM_DIV4;
            default:           presc_limit = `PMT_LIM_DIV16;
        endcase
    endfunction

    // A clear suppresses the tick so a restart begins a whole period.
    assign tick_o = en_i && !clr_i && (cnt_q == presc_limit(sel_i));
    assign cnt_o  = cnt_q;

    // Counts enabled instruction cycles and wraps at the selected limit.
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_q <= 4'h0;
        end else if (en_i) begin
            cnt_q <= tick_o ? 4'h0 : cnt_q + 4'h1;
        end
    end

endmodule

`default_nettype wire

// ==== hw/pmt_regs.svh ====
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH

// Register byte offsets inside the slave window.
`define PMT_CTRL_OFS    8'h00
`define PMT_COUNT_OFS   8'h04
`define PMT_PERIOD_OFS  8'h08
`define PMT_STATUS_OFS  8'h0C
`define PMT_MASK_OFS    8'h10

// Control register fields.
`define PMT_PRESC_LSB   0
`define PMT_ON_BIT      2
`define PMT_POST_LSB    3
`define PMT_CTRL_WMASK  8'h7F

// Status and mask register field.
`define PMT_FLAG_BIT    0

// Reset values.
`define PMT_CTRL_RST    8'h00
`define PMT_COUNT_RST   8'h00
`define PMT_PERIOD_RST  8'hFF

// Instruction clock is the system clock divided by four.
`define PMT_INSTR_LAST  2'h3

// Prescaler terminal counts for divide by 1, 4 and 16.
`define PMT_LIM_DIV1    4'h0
`define PMT_LIM_DIV4    4'h3
`define PMT_LIM_DIV16   4'hF

`endif

// ==== hw/pmt_timer.sv ====
// Overview of operation
// R1: Count upward from zero on prescaled instruction ticks.
// R2: Prescale codes select divide by 1, 4, 16.
// R3: Compare count with period; match is timer output.
// R4: After match reload zero, advance postscaler.
// R5: Reset clears count, period resets to all ones.
// R6: Count, control writes and reset clear scalers.
// R7: Control write leaves the count unchanged.
// R8: Postscale field selects one flag per N matches.
// R9: Timer runs only while the on bit is set.
// R10: Postscaler terminal count sets latched match flag.
// R11: Interrupt requested only while match enable set.
// R12: Unscaled match pulse goes to PWM units.
// R13: Timer output offered as serial shift clock.
// R14: Control bit seven reads zero, ignores writes.
// R15: While off, count and scalers hold their values.
// R16: Match is evaluated only on prescaler ticks.
`include "pmt_regs.svh"
`default_nettype none

module pmt_timer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    output logic             irq_o,
    output logic             match_pulse_o,
    output logic             shift_clk_o
);

    // Bus slave state.
    logic        wr_q;
    logic [7:0]  waddr_q;
    logic        rd_q;
    logic [7:0]  raddr_q;
    logic        hready_q;
    logic        hresp_q;
    logic [31:0] hrdata_q;

    // Timer state.
    logic [1:0]  phase_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  count_q;
    logic [7:0]  period_q;
    logic        flag_q;
    logic        mask_q;
    logic        irq_q;
    logic        match_q;
    logic        shift_q;

    // Decoded strobes and datapath terms.
    logic        accept;
    logic        wr_ctrl;
    logic        wr_count;
    logic        wr_period;
    logic        wr_status;
    logic        wr_mask;
    logic        scaler_clr;
    logic        timer_on;
    logic        instr_tick;
    logic        tmr_tick;
    logic        hit;
    logic        post_tick;
    logic [3:0]  presc_cnt;
    logic [3:0]  post_cnt;

    // Compares a latched bus address against a register offset.
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    // Returns the read value of the register at the given offset.
    function automatic logic [7:0] reg_read(
        input logic [7:0] addr,
        input logic [7:0] ctrl,
        input logic [7:0] count,
        input logic [7:0] period,
        input logic       flag,
        input logic       mask
    );
        reg_read = 8'h00;
        if (reg_hit(addr, `PMT_CTRL_OFS)) begin
            reg_read = ctrl & `PMT_CTRL_WMASK;    // R14
        end else if (reg_hit(addr, `PMT_COUNT_OFS)) begin
            reg_read = count;                      // R5
        end else if (reg_hit(addr, `PMT_PERIOD_OFS)) begin
            reg_read = period;                     // R5
        end else if (reg_hit(addr, `PMT_STATUS_OFS)) begin
            reg_read = {7'h00, flag};
        end else if (reg_hit(addr, `PMT_MASK_OFS)) begin
            reg_read = {7'h00, mask};
        end
    endfunction

    // An address phase is taken when selected, NONSEQ or SEQ (htrans_i[1] set), and the bus is ready.
    assign accept = hsel_i && htrans_i[1] && hready_i;

    // Write strobes are active in the single data-phase cycle.
    assign wr_ctrl   = wr_q && reg_hit(waddr_q, `PMT_CTRL_OFS);
    assign wr_count  = wr_q && reg_hit(waddr_q, `PMT_COUNT_OFS);
    assign wr_period = wr_q && reg_hit(waddr_q, `PMT_PERIOD_OFS);
    assign wr_status = wr_q && reg_hit(waddr_q, `PMT_STATUS_OFS);
    assign wr_mask   = wr_q && reg_hit(waddr_q, `PMT_MASK_OFS);

    // Latches the address phase; reads get one wait state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q     <= 1'b0;
            waddr_q  <= 8'h00;
            rd_q     <= 1'b0;
            raddr_q  <= 8'h00;
            hready_q <= 1'b1;
        end else begin
            wr_q     <= accept && hwrite_i;
            rd_q     <= accept && !hwrite_i;
            hready_q <= !(accept && !hwrite_i);
            if (accept) begin
                waddr_q <= haddr_i[7:0];
                raddr_q <= haddr_i[7:0];
            end
        end
    end

    // Read data are registered in the wait state so writes are already visible.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_q) begin
            hrdata_q <= {24'h000000, reg_read(raddr_q, ctrl_q, count_q, period_q, flag_q, mask_q)};
        end
    end

    // Every transfer completes with an OKAY response.
    always_ff @(posedge clk_i) begin
        hresp_q <= 1'b0;
    end

    // Free-running phase of the instruction clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    assign instr_tick = (phase_q == `PMT_INSTR_LAST);    // R1
    assign timer_on   = ctrl_q[`PMT_ON_BIT];    // R9
    assign scaler_clr = wr_ctrl || wr_count;                // R6

    // Prescaler runs only while on, and holds while off.
    pmt_prescaler u_presc (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (scaler_clr),
        .en_i   (instr_tick && timer_on),    // R9 R15
        .sel_i  (pmt_pkg::pmt_presc_t'(ctrl_q[`PMT_PRESC_LSB +: 2])),    // R2
        .tick_o (tmr_tick),
        .cnt_o  (presc_cnt)
    );

    // Period match is only looked at on a prescaled tick.
    assign hit = tmr_tick && (count_q == period_q);    // R3 R16

    // Postscaler counts unscaled matches.
    pmt_postscaler u_post (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (scaler_clr),
        .en_i   (hit),
        .sel_i  (ctrl_q[`PMT_POST_LSB +: 4]),    // R8
        .tick_o (post_tick),
        .cnt_o  (post_cnt)
    );

    // Control register; bit seven is never stored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `PMT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= hwdata_i[7:0] & `PMT_CTRL_WMASK;    // R14
        end
    end

    // Timer count; a software write wins over a tick.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= `PMT_COUNT_RST;    // R5
        end else if (wr_count) begin    // R7
            count_q <= hwdata_i[7:0];
        end else if (tmr_tick) begin
            count_q <= hit ? 8'h00 : count_q + 8'h01;    // R1 R4
        end
    end

    // Period register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_q <= `PMT_PERIOD_RST;    // R5
        end else if (wr_period) begin
            period_q <= hwdata_i[7:0];
        end
    end

    // Sticky match flag; a new event wins over a write-one clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (post_tick) begin
            flag_q <= 1'b1;    // R10
        end else if (wr_status && hwdata_i[`PMT_FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    // Interrupt enable mask.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= 1'b0;
        end else if (wr_mask) begin
            mask_q <= hwdata_i[`PMT_FLAG_BIT];
        end
    end

    // Interrupt level follows the flag gated by the enable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q && mask_q;    // R11
        end
    end

    // Unscaled match pulse and the derived shift clock toggling on each match.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_q <= 1'b0;
            shift_q <= 1'b0;
        end else begin
            match_q <= hit;    // R12
            if (hit) begin
                shift_q <= !shift_q;    // R13
            end
        end
    end

    assign hreadyout_o   = hready_q;
    assign hresp_o       = hresp_q;
    assign hrdata_o      = hrdata_q;
    assign irq_o         = irq_q;
    assign match_pulse_o = match_q;
    assign shift_clk_o   = shift_q;

    // Checks on the timer behaviour.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_count_restart: assert property (hit && !wr_count |=> count_q == 8'h00) // R4
        else $error("count did not restart after match");

    a_count_step: assert property (tmr_tick && !hit && !wr_count |=> count_q == $past(count_q) + 8'h01) // R1
        else $error("count did not advance on tick");

    a_tick_needs_on: assert property (tmr_tick |-> timer_on && instr_tick) // R9
        else $error("tick while off or off instruction phase");

    a_off_hold: assert property (!timer_on && !wr_count && !wr_ctrl |=> $stable(count_q)
        && $stable(presc_cnt) && $stable(post_cnt)) // R15
        else $error("timer state moved while off");

    a_ctrl_keeps: assert property (wr_ctrl |=> $stable(count_q)) // R7
        else $error("control write changed count");

    a_scaler_clear: assert property (scaler_clr |=> presc_cnt == 4'h0 && post_cnt == 4'h0) // R6
        else $error("scalers not cleared");

    a_presc_ratio: assert property (tmr_tick && ctrl_q[1:0] == 2'h1 |-> presc_cnt == `PMT_LIM_DIV4) // R2
        else $error("divide by four ratio wrong");

    a_presc_sixteen: assert property (tmr_tick && ctrl_q[1] |-> presc_cnt == `PMT_LIM_DIV16) // R2
        else $error("divide by sixteen ratio wrong");

    a_match_only_tick: assert property (match_pulse_o |-> $past(tmr_tick) && $past(count_q == period_q)) // R3 R16
        else $error("match pulse without tick match");

    a_post_ratio: assert property (post_tick |-> post_cnt == ctrl_q[6:3] && hit) // R8
        else $error("postscaler ratio wrong");

    a_flag_sticky: assert property (flag_q && !(wr_status && hwdata_i[0]) |=> flag_q) // R10
        else $error("flag dropped without clear");

    a_flag_set: assert property (post_tick |=> flag_q ##1 (irq_o == mask_q || $changed(mask_q))) // R10 R11
        else $error("flag or interrupt not raised");

    a_irq_gate: assert property (irq_o |-> $past(flag_q) && $past(mask_q)) // R11
        else $error("interrupt without enabled flag");

    a_shift_clk: assert property (match_pulse_o |-> shift_clk_o != $past(shift_clk_o)) // R13
        else $error("shift clock did not toggle");

    a_bit7_zero: assert property (rd_q && raddr_q == `PMT_CTRL_OFS |=> hrdata_o[7] == 1'b0 && hreadyout_o) // R14
        else $error("control bit seven read nonzero");

    a_reset_state: assert property (disable iff (1'b0) rst_i |=> count_q == `PMT_COUNT_RST
        && period_q == `PMT_PERIOD_RST && presc_cnt == 4'h0 && post_cnt == 4'h0 && !flag_q
        && !irq_o && !match_pulse_o && !shift_clk_o && hreadyout_o) // R5
        else $error("reset values wrong");

    // Register loads, postscaler advance, the interrupt and the corner cases of the sticky flag.
    a_count_load: assert property (wr_count |=> count_q == $past(hwdata_i[7:0])) // R5
        else $error("count write not loaded");

    a_period_load: assert property (wr_period |=> period_q == $past(hwdata_i[7:0])) // R5
        else $error("period write not loaded");

    a_period_hold: assert property (!wr_period |=> $stable(period_q)) // R5
        else $error("period changed without write");

    a_flag_set_wins: assert property (post_tick && wr_status && hwdata_i[0] |=> flag_q) // R10
        else $error("clear beat a new flag event");

    a_flag_clear: assert property (flag_q && wr_status && hwdata_i[0] && !post_tick |=> !flag_q) // R10
        else $error("flag not cleared by write one");

    a_post_count: assert property (hit && !post_tick |=> post_cnt == $past(post_cnt) + 4'h1) // R4
        else $error("postscaler did not advance on match");

    a_irq_low: assert property (!flag_q |=> !irq_o) // R11
        else $error("interrupt without flag");

    c_match: cover property (hit ##1 match_pulse_o);
    c_flag_irq: cover property (post_tick ##2 irq_o);
    c_post_16: cover property (post_tick && ctrl_q[6:3] == 4'hF);
    c_set_clear: cover property (post_tick && wr_status && hwdata_i[0]);
    c_count_write: cover property (wr_count && timer_on);

endmodule

`default_nettype wire

// ==== verif/period_match_timer8_tb_top.sv ====
`include "pmt_regs.svh"
`default_nettype none

`define PMT_CHK(nm, ex, gt) \
    begin \
        check_count++; \
        if ((gt) !== (ex)) begin \
            n_mismatch++; \
            $display("Error %s expected %0h seen %0h", nm, ex, gt); \
        end \
    end

module period_match_timer8_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i;
    logic        rst_i;
    wire logic        hsel;
    wire logic [31:0] haddr;
    wire logic [1:0]  htrans;
    wire logic        hwrite;
    wire logic [2:0]  hsize;
    wire logic [31:0] hwdata;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic [31:0] hrdata;
    wire logic        irq_o;
    wire logic        match_pulse;
    wire logic        shift_clk;
    int          n_mismatch;
    int          check_count;
    int          per;
    logic [15:0] p0;
    logic [15:0] e0;
    logic [3:0]  post_codes [4] = '{4'h0, 4'h1, 4'h6, 4'hF};

    pmt_core_model core (
        .clk_i(clk_i), .hready_i(hreadyout), .hrdata_i(hrdata), .match_pulse_i(match_pulse),
        .shift_clk_i(shift_clk), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata)
    );

    pmt_timer dut (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .irq_o(irq_o),
        .match_pulse_o(match_pulse), .shift_clk_o(shift_clk)
    );

    // Free-running 125 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    function automatic logic [31:0] ctl(input logic [3:0] post, input logic on, input logic [1:0] ps);
        return {24'h000000, 1'b0, post, on, ps};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        core.xfer(1'b1, a, v, d);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] d;
        core.xfer(1'b0, a, 32'h00000000, d);
        `PMT_CHK(nm, ex, d)
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end

    // Main sequence of register accesses and timing checks.
    initial begin
        n_mismatch  = 0;
        check_count = 0;
        rst_i       = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("ctrl", `PMT_CTRL_OFS, 32'h00000000);
        rdchk("count", `PMT_COUNT_OFS, 32'h00000000);
        rdchk("period", `PMT_PERIOD_OFS, 32'h000000FF);
        rdchk("status", `PMT_STATUS_OFS, 32'h00000000);
        rdchk("mask", `PMT_MASK_OFS, 32'h00000000);
        rdchk("unmapped", 8'h14, 32'h00000000);
        `PMT_CHK("hresp", 1'b0, hresp)
        wr(`PMT_CTRL_OFS, 32'h000000FF);
        rdchk("ctrl", `PMT_CTRL_OFS, 32'h0000007F);
        wr(`PMT_CTRL_OFS, 32'h00000000);
        wr(`PMT_COUNT_OFS, 32'h00000003);
        wr(`PMT_CTRL_OFS, ctl(4'h5, 1'b0, 2'h1));
        rdchk("count", `PMT_COUNT_OFS, 32'h00000003);
        rdchk("ctrl", `PMT_CTRL_OFS, 32'h00000029);
        repeat (40) @(posedge clk_i);
        rdchk("count", `PMT_COUNT_OFS, 32'h00000003);
        wr(`PMT_PERIOD_OFS, 32'h00000005);
        rdchk("period", `PMT_PERIOD_OFS, 32'h00000005);
        // Match rate for every prescale code with a period value of two.
        wr(`PMT_PERIOD_OFS, 32'h00000002);
        for (int ps = 0; ps < 4; ps++) begin
            per = 12 * ((ps == 0) ? 1 : (ps == 1) ? 4 : 16);
            wr(`PMT_COUNT_OFS, 32'h00000000);
            wr(`PMT_CTRL_OFS, ctl(4'h0, 1'b1, ps[1:0]));
            repeat (per + 8) @(posedge clk_i);
            p0 = core.pulse_cnt;
            e0 = core.edge_cnt;
            repeat (3 * per) @(posedge clk_i);
            `PMT_CHK("match pulses", 16'h0003, core.pulse_cnt - p0)
            `PMT_CHK("shift edges", 16'h0003, core.edge_cnt - e0)
            wr(`PMT_CTRL_OFS, 32'h00000000);
        end
        // Flag latches while masked, the request follows the mask, a written one clears it.
        wr(`PMT_STATUS_OFS, 32'h00000001);
        wr(`PMT_PERIOD_OFS, 32'h00000000);
        wr(`PMT_CTRL_OFS, ctl(4'h0, 1'b1, 2'h0));
        repeat (20) @(posedge clk_i);
        `PMT_CHK("irq masked", 1'b0, irq_o)
        rdchk("status", `PMT_STATUS_OFS, 32'h00000001);
        wr(`PMT_MASK_OFS, 32'h00000001);
        repeat (2) @(posedge clk_i);
        `PMT_CHK("irq enabled", 1'b1, irq_o)
        wr(`PMT_CTRL_OFS, 32'h00000000);
        rdchk("count", `PMT_COUNT_OFS, 32'h00000000);
        wr(`PMT_STATUS_OFS, 32'h00000001);
        repeat (2) @(posedge clk_i);
        `PMT_CHK("irq cleared", 1'b0, irq_o)
        rdchk("status", `PMT_STATUS_OFS, 32'h00000000);
        // Postscaler: the first flag comes after code plus one matches.
        foreach (post_codes[i]) begin
            wr(`PMT_COUNT_OFS, 32'h00000000);
            wr(`PMT_CTRL_OFS, ctl(post_codes[i], 1'b1, 2'h0));
            p0 = core.pulse_cnt;
            while (irq_o !== 1'b1) @(posedge clk_i);
            `PMT_CHK("post matches", {12'h000, post_codes[i]} + 16'h0001, core.pulse_cnt - p0)
            wr(`PMT_CTRL_OFS, 32'h00000000);
            wr(`PMT_STATUS_OFS, 32'h00000001);
            repeat (2) @(posedge clk_i);
        end
        // A second reset in mid-run returns count, period, control and mask to their reset values.
        wr(`PMT_COUNT_OFS, 32'h00000009);
        wr(`PMT_PERIOD_OFS, 32'h00000007);
        wr(`PMT_CTRL_OFS, ctl(4'h3, 1'b0, 2'h2));
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("count", `PMT_COUNT_OFS, 32'h00000000);
        rdchk("period", `PMT_PERIOD_OFS, 32'h000000FF);
        rdchk("ctrl", `PMT_CTRL_OFS, 32'h00000000);
        rdchk("mask", `PMT_MASK_OFS, 32'h00000000);
        test_done();
    end
endmodule

`default_nettype wire

// ==== verif/pmt_core_model.sv ====
`default_nettype none

module pmt_core_model (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    input  wire logic        match_pulse_i,
    input  wire logic        shift_clk_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] pulse_cnt;
    logic [15:0] edge_cnt;
    logic        shift_prev;

    // The bus starts idle and the event counters start from zero.
    initial begin
        hsel_o     = 1'b0;
        haddr_o    = 32'h00000000;
        htrans_o   = 2'h0;
        hwrite_o   = 1'b0;
        hsize_o    = 3'h2;
        hwdata_o   = 32'h00000000;
        pulse_cnt  = 16'h0000;
        edge_cnt   = 16'h0000;
        shift_prev = 1'b0;
    end

    // The PWM and serial side count unscaled match pulses and shift clock edges.
    always @(posedge clk_i) begin
        if (match_pulse_i === 1'b1) begin
            pulse_cnt <= pulse_cnt + 16'h0001;
        end
        if (shift_clk_i !== shift_prev) begin
            edge_cnt <= edge_cnt + 16'h0001;
        end
        shift_prev <= shift_clk_i;
    end

    // One single word transfer; the address phase is held until hready is seen high.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        hsel_o   <= 1'b1;
        haddr_o  <= {24'h000000, addr};
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        hsize_o  <= 3'h2;
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
        htrans_o <= 2'h0;
        hsel_o   <= 1'b0;
        hwdata_o <= wr ? wdata : ~hwdata_o;
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
        rdata = hrdata_i;
        hwdata_o <= ~wdata;
    endtask
endmodule

`default_nettype wire
